/* File: hw/cwu_pkg.sv */
package cwu_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] CWU_OFS_CTRL = 5'h00;
    localparam logic [4:0] CWU_OFS_RISE = 5'h04;
    localparam logic [4:0] CWU_OFS_FALL = 5'h08;
    localparam logic [4:0] CWU_OFS_SHDN = 5'h0C;
    localparam logic [4:0] CWU_OFS_STAT = 5'h10;

    // widths
    localparam int CWU_ADDR_W = 5;
    localparam int CWU_DATA_W = 32;
    localparam int CWU_DLY_W = 6;

    // control register fields
    localparam int CWU_CTRL_EN_BIT = 0;

    // shutdown_config_reg fields
    localparam int CWU_SHDN_FLAG_BIT = 0;
    localparam int CWU_SHDN_AUTO_BIT = 1;
    localparam int CWU_SHDN_CMP_BIT = 2;
    localparam int CWU_SHDN_FLT_BIT = 3;
    localparam int CWU_SHDN_OVA_BIT = 4;
    localparam int CWU_SHDN_OVB_BIT = 5;

    // status register fields
    localparam int CWU_STAT_PRI_BIT = 0;
    localparam int CWU_STAT_CMP_BIT = 1;
    localparam int CWU_STAT_SHDN_BIT = 2;
    localparam int CWU_STAT_TRIP_BIT = 3;
    localparam int CWU_STAT_FAULT_BIT = 4;
    localparam int CWU_STAT_SRC_BIT = 5;

    // reset values
    localparam logic CWU_CTRL_EN_RST = 1'b0;
    localparam logic [5:0] CWU_DLY_RST = 6'h00;
    localparam logic [5:0] CWU_SHDN_RST = 6'h00;
    localparam logic [31:0] CWU_RDATA_RST = 32'h0000_0000;
endpackage : cwu_pkg

/* File: hw/cwu_db_if.sv */
`timescale 1ns/1ps
interface cwu_db_if;
    logic src_level;
    logic hold;
    logic [5:0] rise_delay;
    logic [5:0] fall_delay;
    logic primary_req;
    logic comp_req;

    modport ctrl (output src_level, output hold, output rise_delay, output fall_delay,
                  input primary_req, input comp_req);
    modport counter (input src_level, input hold, input rise_delay, input fall_delay,
                     output primary_req, output comp_req);
endinterface : cwu_db_if

/* File: hw/cwu_deadband.sv */
`timescale 1ns/1ps
module cwu_deadband (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // link to the control logic
    cwu_db_if.counter db
);
    ////////////////////////////////////////////////////////////////////////
    logic [5:0] rise_cnt_ff;
    logic [5:0] fall_cnt_ff;
    logic [5:0] nxt_rise_cnt;
    logic [5:0] nxt_fall_cnt;
    logic rise_done;
    logic fall_done;

    // done once the count has reached the programmed value
    assign rise_done = (rise_cnt_ff == db.rise_delay);
    assign fall_done = (fall_cnt_ff == db.fall_delay);

    // each counter runs from zero while its level lasts, else drops to zero
    assign nxt_rise_cnt = (db.hold || !db.src_level) ? 6'h00 :
                          (rise_done ? rise_cnt_ff : rise_cnt_ff + 6'h01);
    assign nxt_fall_cnt = (db.hold || db.src_level) ? 6'h00 :
                          (fall_done ? fall_cnt_ff : fall_cnt_ff + 6'h01);

    // requests can never overlap: each needs the opposite source level
    assign db.primary_req = db.src_level && !db.hold && rise_done;
    assign db.comp_req = !db.src_level && !db.hold && fall_done;

    ////////////////////////////////////////////////////////////////////////
    // counter registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rise_cnt_ff <= 6'h00;
            fall_cnt_ff <= 6'h00;
        end else begin
            rise_cnt_ff <= nxt_rise_cnt;
            fall_cnt_ff <= nxt_fall_cnt;
        end
    end
endmodule : cwu_deadband

/* File: hw/cwu_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - two independent 6-bit rise and fall counters
// - count clocks from zero up to setting
// - rise: complementary off, primary after delay
// - fall: primary off, complementary after delay
// - rise delay spans zero to sixty-three counts
// - fall delay spans zero to sixty-three counts
// - zero setting means no dead band
// - too short pulse keeps output off
// - async input adds at most one clock
// - software flag forces override levels
// - without auto-restart, held until software clears
// - auto-restart clears flag at next rise
// - enabled fault input overrides outputs immediately
// - comparator and fault pin individually selectable
// - level sensitive; persists while input active
module cwu_top (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // avalon-mm slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // waveform source and shutdown inputs
    input wire logic source_in,
    input wire logic comparator_trip_input_in,
    input wire logic fault_pin_input_in,
    // gate drive outputs
    output logic primary_drive_out,
    output logic complementary_drive_out
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers: all three inputs are asynchronous to clk_in
    logic [1:0] src_sync_ff;
    logic [1:0] trip_sync_ff;
    logic [1:0] fault_sync_ff;
    logic src_prev_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            src_sync_ff <= 2'h0;
            trip_sync_ff <= 2'h0;
            fault_sync_ff <= 2'h0;
            src_prev_ff <= 1'b0;
        end else begin
            src_sync_ff <= {src_sync_ff[0], source_in};
            trip_sync_ff <= {trip_sync_ff[0], comparator_trip_input_in};
            fault_sync_ff <= {fault_sync_ff[0], fault_pin_input_in};
            src_prev_ff <= src_sync_ff[1];
        end
    end

    // only stage 1 is read by logic; sampling jitter is one clock at most
    logic src_level;
    logic trip_level;
    logic fault_level;
    logic src_rise;
    assign src_level = src_sync_ff[1];
    assign trip_level = trip_sync_ff[1];
    assign fault_level = fault_sync_ff[1];
    assign src_rise = src_level && !src_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, then the access completes
    logic ack_ff;
    logic bus_req;
    logic wr_go;
    logic wr_lo;
    logic sel_ctrl;
    logic sel_rise;
    logic sel_fall;
    logic sel_shdn;
    logic sel_stat;

    assign bus_req = avs_read_in || avs_write_in;
    assign avs_waitrequest_out = bus_req && !ack_ff;
    assign wr_go = avs_write_in && ack_ff;
    assign wr_lo = wr_go && avs_byteenable_in[0];

    // one offset compare, shared by all the register selects
    function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] ofs);
        return (addr == ofs);
    endfunction : addr_hit

    assign sel_ctrl = addr_hit(avs_address_in, cwu_pkg::CWU_OFS_CTRL);
    assign sel_rise = addr_hit(avs_address_in, cwu_pkg::CWU_OFS_RISE);
    assign sel_fall = addr_hit(avs_address_in, cwu_pkg::CWU_OFS_FALL);
    assign sel_shdn = addr_hit(avs_address_in, cwu_pkg::CWU_OFS_SHDN);
    assign sel_stat = addr_hit(avs_address_in, cwu_pkg::CWU_OFS_STAT);

    // ack drops after one completed beat so back-to-back requests wait again
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req && !ack_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic en_ff;
    logic [5:0] rise_dly_ff;
    logic [5:0] fall_dly_ff;
    logic auto_restart_ff;
    logic cmp_sel_ff;
    logic flt_sel_ff;
    logic ovr_pri_ff;
    logic ovr_comp_ff;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            en_ff <= cwu_pkg::CWU_CTRL_EN_RST;
            rise_dly_ff <= cwu_pkg::CWU_DLY_RST;
            fall_dly_ff <= cwu_pkg::CWU_DLY_RST;
            auto_restart_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_AUTO_BIT];
            cmp_sel_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_CMP_BIT];
            flt_sel_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_FLT_BIT];
            ovr_pri_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_OVA_BIT];
            ovr_comp_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_OVB_BIT];
        end else if (wr_lo) begin
            if (sel_ctrl) begin
                en_ff <= avs_writedata_in[cwu_pkg::CWU_CTRL_EN_BIT];
            end
            if (sel_rise) begin
                rise_dly_ff <= avs_writedata_in[5:0];
            end
            if (sel_fall) begin
                fall_dly_ff <= avs_writedata_in[5:0];
            end
            if (sel_shdn) begin
                auto_restart_ff <= avs_writedata_in[cwu_pkg::CWU_SHDN_AUTO_BIT];
                cmp_sel_ff <= avs_writedata_in[cwu_pkg::CWU_SHDN_CMP_BIT];
                flt_sel_ff <= avs_writedata_in[cwu_pkg::CWU_SHDN_FLT_BIT];
                ovr_pri_ff <= avs_writedata_in[cwu_pkg::CWU_SHDN_OVA_BIT];
                ovr_comp_ff <= avs_writedata_in[cwu_pkg::CWU_SHDN_OVB_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shutdown state
    logic shdn_flag_ff;
    logic nxt_shdn_flag;
    logic ext_trip;
    logic sw_write_flag;
    logic auto_clear;
    logic shdn_active;

    // any selected input, on level, trips shutdown
    assign ext_trip = (cmp_sel_ff && trip_level) || (flt_sel_ff && fault_level);
    assign sw_write_flag = wr_lo && sel_shdn;
    // auto-restart only releases on a source rise with no trip pending
    assign auto_clear = auto_restart_ff && src_rise && !ext_trip;

    // hardware set beats any clear in the same cycle
    assign nxt_shdn_flag = ext_trip ? 1'b1 :
                           sw_write_flag ? avs_writedata_in[cwu_pkg::CWU_SHDN_FLAG_BIT] :
                           auto_clear ? 1'b0 :
                           shdn_flag_ff;

    // the trip level bypasses the flag so outputs react without waiting
    assign shdn_active = shdn_flag_ff || ext_trip;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shdn_flag_ff <= cwu_pkg::CWU_SHDN_RST[cwu_pkg::CWU_SHDN_FLAG_BIT];
        end else begin
            shdn_flag_ff <= nxt_shdn_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dead-band counters; held at zero while off so recovery re-times
    cwu_db_if db_link ();

    assign db_link.src_level = src_level;
    assign db_link.hold = shdn_active || !en_ff;
    assign db_link.rise_delay = rise_dly_ff;
    assign db_link.fall_delay = fall_dly_ff;

    cwu_deadband u_deadband (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .db(db_link.counter)
    );

    ////////////////////////////////////////////////////////////////////////
    // drive outputs from flip-flops; override levels win in shutdown
    logic pri_ff;
    logic comp_ff;
    logic nxt_pri;
    logic nxt_comp;

    assign nxt_pri = shdn_active ? ovr_pri_ff :
                     (en_ff && db_link.primary_req);
    assign nxt_comp = shdn_active ? ovr_comp_ff :
                      (en_ff && db_link.comp_req);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pri_ff <= 1'b0;
            comp_ff <= 1'b0;
        end else begin
            pri_ff <= nxt_pri;
            comp_ff <= nxt_comp;
        end
    end

    assign primary_drive_out = pri_ff;
    assign complementary_drive_out = comp_ff;

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the wait cycle so it stands when ack rises
    logic [31:0] rd_mux;
    logic [31:0] shdn_word;
    logic [31:0] stat_word;

    // shutdown word, fields placed by their bit positions; spare bits read zero
    always_comb begin
        shdn_word = cwu_pkg::CWU_RDATA_RST;
        shdn_word[cwu_pkg::CWU_SHDN_FLAG_BIT] = shdn_flag_ff;
        shdn_word[cwu_pkg::CWU_SHDN_AUTO_BIT] = auto_restart_ff;
        shdn_word[cwu_pkg::CWU_SHDN_CMP_BIT] = cmp_sel_ff;
        shdn_word[cwu_pkg::CWU_SHDN_FLT_BIT] = flt_sel_ff;
        shdn_word[cwu_pkg::CWU_SHDN_OVA_BIT] = ovr_pri_ff;
        shdn_word[cwu_pkg::CWU_SHDN_OVB_BIT] = ovr_comp_ff;
    end

    // status word shows synced levels, so software sees what the logic sees
    always_comb begin
        stat_word = cwu_pkg::CWU_RDATA_RST;
        stat_word[cwu_pkg::CWU_STAT_PRI_BIT] = pri_ff;
        stat_word[cwu_pkg::CWU_STAT_CMP_BIT] = comp_ff;
        stat_word[cwu_pkg::CWU_STAT_SHDN_BIT] = shdn_active;
        stat_word[cwu_pkg::CWU_STAT_TRIP_BIT] = trip_level;
        stat_word[cwu_pkg::CWU_STAT_FAULT_BIT] = fault_level;
        stat_word[cwu_pkg::CWU_STAT_SRC_BIT] = src_level;
    end
    // unmapped offsets read as zero
    assign rd_mux = sel_ctrl ? {31'h0, en_ff} :
                    sel_rise ? {26'h0, rise_dly_ff} :
                    sel_fall ? {26'h0, fall_dly_ff} :
                    sel_shdn ? shdn_word :
                    sel_stat ? stat_word :
                    32'h0000_0000;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= cwu_pkg::CWU_RDATA_RST;
        end else if (avs_read_in && !ack_ff) begin
            avs_readdata_out <= rd_mux;
        end
    end
endmodule : cwu_top

/* File: verif/cwu_assertions.sv */
`timescale 1ns/1ps
module cwu_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // register bus
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic [31:0] avs_readdata_out,
    // waveform side
    input wire logic source_in,
    input wire logic primary_drive_out,
    input wire logic complementary_drive_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // any bus request in progress
    wire req = avs_read_in | avs_write_in;
    sequence req_new;
        req && !$past(req);
    endsequence
    sequence req_waiting;
        req && avs_waitrequest_out;
    endsequence
    first_wait_a: assert property (req_new |-> avs_waitrequest_out) else $error("no wait cycle");
    one_wait_a: assert property (req_waiting |=> !avs_waitrequest_out) else $error("wait too long");
    idle_wait_a: assert property (!req |-> !avs_waitrequest_out) else $error("wait while idle");
    upper_zero_a: assert property (avs_readdata_out[31:6] == 26'h0) else $error("upper bits set");
    no_overlap_a: assert property (!(primary_drive_out && complementary_drive_out)) else $error("overlap");
    // pin to drive is two sync stages plus the output flop, so look three ticks back
    pri_rise_a: assert property ($rose(primary_drive_out) |-> $past(source_in, 3)) else $error("early on");
    comp_rise_a: assert property ($rose(complementary_drive_out) |-> !$past(source_in, 3)) else $error("early");
    // reset holds both drives off, so no disable here
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst_in |=> !primary_drive_out && !complementary_drive_out)
        else $error("drive in reset");
endmodule : cwu_chk
bind cwu_top cwu_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out),
    .source_in(source_in), .primary_drive_out(primary_drive_out), .complementary_drive_out(complementary_drive_out));

/* File: verif/cwu_gate_model.sv */
`timescale 1ns/1ps
module cwu_gate_model (
    // gate commands from the unit
    input wire logic clk_in,
    input wire logic hi_gate_in,
    input wire logic lo_gate_in,
    // shoot-through cycles seen
    output int shoot_cnt_out
);
    initial shoot_cnt_out = 0;
    // both legs on would short the supply rail
    always @(posedge clk_in) begin
        if (hi_gate_in === 1'b1 && lo_gate_in === 1'b1) shoot_cnt_out <= shoot_cnt_out + 1;
    end
endmodule : cwu_gate_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [4:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    logic [3:0] avs_byteenable_in;
    logic source_in, comparator_trip_input_in, fault_pin_input_in, primary_drive_out, complementary_drive_out;
    int n_errors = 0, samples_checked = 0, shoot_cnt, n;
    int dq[$];
    cwu_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .source_in(source_in),
        .comparator_trip_input_in(comparator_trip_input_in), .fault_pin_input_in(fault_pin_input_in),
        .primary_drive_out(primary_drive_out), .complementary_drive_out(complementary_drive_out));
    cwu_gate_model u_gate (.clk_in(clk_in), .hi_gate_in(primary_drive_out), .lo_gate_in(complementary_drive_out),
        .shoot_cnt_out(shoot_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        do begin
            @(posedge clk_in);
            i++;
        end while (avs_waitrequest_out !== 1'b0 && i < 50);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (i >= 50) begin
            n_errors++;
            give_verdict;
        end
    endtask : bus
    // counts edges until the chosen drive shows lvl; bounded
    task wait_out(input logic lvl, input logic pri, input int lim, output int cnt);
        cnt = 0;
        while ((pri ? primary_drive_out : complementary_drive_out) !== lvl) begin
            @(posedge clk_in);
            cnt++;
            if (cnt > lim) begin
                n_errors++;
                give_verdict;
            end
        end
    endtask : wait_out
    // source edge: the off drive drops, the on drive follows d clocks later
    task edge_run(input logic lvl, input int d);
        @(posedge clk_in);
        source_in <= lvl;
        wait_out(1'b0, !lvl, 20, n);
        wait_out(1'b1, lvl, 80, n);
        chk("dead band", n, d);
    endtask : edge_run
    initial begin
        repeat (100000) @(posedge clk_in);
        n_errors++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst_in, avs_read_in, avs_write_in, source_in} = 4'h8;
        {comparator_trip_input_in, fault_pin_input_in, avs_address_in, avs_writedata_in} = '0;
        avs_byteenable_in = 4'hF;
        void'($urandom(66));
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        // reset values, last offset unmapped
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 5'(a * 4), 32'h0);
            chk("reset read", rd, 32'h0);
        end
        bus(1'b1, cwu_pkg::CWU_OFS_CTRL, 32'h1);
        dq = {0, 63, $urandom_range(62, 1)};
        foreach (dq[k]) begin
            bus(1'b1, cwu_pkg::CWU_OFS_RISE, dq[k]);
            bus(1'b1, cwu_pkg::CWU_OFS_FALL, 63 - dq[k]);
            bus(1'b0, cwu_pkg::CWU_OFS_RISE, 32'h0);
            chk("rise reg", rd, dq[k]);
            repeat (70) @(posedge clk_in);
            edge_run(1'b1, dq[k]);
            edge_run(1'b0, 63 - dq[k]);
        end
        // pulse shorter than the rise delay
        bus(1'b1, cwu_pkg::CWU_OFS_RISE, 32'h14);
        source_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        source_in <= 1'b0;
        n = 0;
        repeat (80) @(posedge clk_in) n += primary_drive_out;
        chk("short pulse", n, 0);
        // lane 0 disabled: the write must not land
        avs_byteenable_in <= 4'hE;
        bus(1'b1, cwu_pkg::CWU_OFS_RISE, 32'h2B);
        avs_byteenable_in <= 4'hF;
        bus(1'b0, cwu_pkg::CWU_OFS_RISE, 32'h0);
        chk("lane off", rd, 32'h14);
        // software shutdown, both overrides low, held while set
        bus(1'b1, cwu_pkg::CWU_OFS_SHDN, 32'h1);
        repeat (10) @(posedge clk_in);
        chk("sw override", {primary_drive_out, complementary_drive_out}, 0);
        bus(1'b0, cwu_pkg::CWU_OFS_STAT, 32'h0);
        chk("stat shdn", rd[2], 1);
        bus(1'b1, cwu_pkg::CWU_OFS_SHDN, 32'h0);
        wait_out(1'b1, 1'b0, 80, n);
        // auto restart clears at the next source rise
        bus(1'b1, cwu_pkg::CWU_OFS_SHDN, 32'h3);
        repeat (5) @(posedge clk_in);
        chk("auto override", complementary_drive_out, 0);
        source_in <= 1'b1;
        wait_out(1'b1, 1'b1, 80, n);
        bus(1'b0, cwu_pkg::CWU_OFS_SHDN, 32'h0);
        chk("auto clear", rd, 32'h2);
        // unselected inputs are ignored
        bus(1'b1, cwu_pkg::CWU_OFS_SHDN, 32'h0);
        {comparator_trip_input_in, fault_pin_input_in} <= 2'h3;
        repeat (8) @(posedge clk_in);
        chk("unselected", primary_drive_out, 1);
        {comparator_trip_input_in, fault_pin_input_in} <= 2'h0;
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, cwu_pkg::CWU_OFS_SHDN, s ? 32'h8 : 32'h4);
            {comparator_trip_input_in, fault_pin_input_in} <= s ? 2'h1 : 2'h2;
            // sync stages plus one clock of sampling jitter
            repeat (5) @(posedge clk_in);
            chk("trip override", primary_drive_out, 0);
            bus(1'b1, cwu_pkg::CWU_OFS_SHDN, s ? 32'h8 : 32'h4);
            bus(1'b0, cwu_pkg::CWU_OFS_SHDN, 32'h0);
            chk("held", rd[0], 1);
            {comparator_trip_input_in, fault_pin_input_in} <= 2'h0;
            repeat (4) @(posedge clk_in);
            bus(1'b1, cwu_pkg::CWU_OFS_SHDN, 32'h0);
            wait_out(1'b1, 1'b1, 80, n);
        end
        chk("shoot through", shoot_cnt, 0);
        give_verdict;
    end
endmodule : tb_top
